// >>> verilog/rtcc_ctrl.sv
//Behaviour
//(RULE1) Timer counts while run bit is 1, holds while 0; an auto-reset alarm match still zeroes it while stopped.
//(RULE2) Writing alarm-enable turns alarm on/off and clears alarm flag.
//(RULE3) Alarm bit reads flag; writing it stores auto-reset enable.
//(RULE4) Alarm flag lasts at most one oscillator cycle, then self-clears; it stays set while a stopped timer sits at the alarm value.
//(RULE5) Writing 1 to load request copies capture into timer; cleared when done.
//(RULE6) Writing 1 to snapshot request copies timer into capture; cleared when done.
//(RULE7) Gain control enabled when its bit is 1, off when 0.
//(RULE8) Mode bit: 0 self-oscillate, 1 crystal.
//(RULE9) Bias doubling active when its bit is 1.
//(RULE10) Oscillation-valid bit reads 1 when amplitude suffices, else 0.
//(RULE11) Low-frequency select 1 forces internal oscillator source; 0 lets mode decide.
//(RULE12) Low three oscillator-control bits read zero, writes ignored.
`timescale 1ns/100ps
module rtcc_ctrl #(
    parameter int TIMER_W = 32
) (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       osc_tick,
    input  wire logic       amp_ok,
    output logic            gain_control_enable,
    output logic            crystal_mode,
    output logic            bias_doubling_enable,
    output logic            lfo_enable,
    output logic      [1:0] clock_source,
    output logic            alarm_event
);
    ////////////////////////////////////////////////////////////////////////////////
    logic                 timer_run_r;
    logic                 alarm_enable_r;
    logic                 autoreset_r;
    logic                 load_req_r;
    logic                 snap_req_r;
    logic                 alarm_flag_r;
    logic                 gain_r;
    logic                 mode_r;
    logic                 bias_r;
    logic                 lfo_r;
    logic                 valid_r;
    logic [7:0]           capt_r  [4];
    logic [7:0]           alarm_r [4];
    logic [7:0]           rdata_nxt;
    logic [TIMER_W-1:0]   count;
    logic [TIMER_W-1:0]   capt_word;
    logic [TIMER_W-1:0]   alarm_word;
    logic [TIMER_W-1:0]   load_val;
    logic                 wr_tactl;
    logic                 wr_osc;
    logic                 match;
    logic                 timer_load;
    logic                 alarm_flag_nxt;

    assign wr_tactl   = reg_wr && (reg_addr == rtcc_pkg::TACTL_ADDR);
    assign wr_osc     = reg_wr && (reg_addr == rtcc_pkg::OSCCTL_ADDR);
    assign capt_word  = {capt_r[3], capt_r[2], capt_r[1], capt_r[0]};
    assign alarm_word = {alarm_r[3], alarm_r[2], alarm_r[1], alarm_r[0]};

    // Compare on every tick while the alarm is enabled, whether or not the timer is running
    assign match      = osc_tick && alarm_enable_r && (count == alarm_word);
    // Auto-reset restarts the timer from zero on the matching tick
    assign timer_load = load_req_r || (match && autoreset_r);
    assign load_val   = load_req_r ? capt_word : '0; // RULE5

    ////////////////////////////////////////////////////////////////////////////////
    rtcc_timer #(
        .WIDTH    (TIMER_W)
    ) u_timer (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .run      (timer_run_r),
        .tick     (osc_tick),
        .load     (timer_load),
        .load_val (load_val),
        .count_r  (count)
    );

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            timer_run_r    <= 1'b0;
            alarm_enable_r <= 1'b0;
            autoreset_r    <= 1'b0;
        end else if (wr_tactl) begin
            timer_run_r    <= reg_wdata[rtcc_pkg::TRUN_BIT]; // RULE1
            alarm_enable_r <= reg_wdata[rtcc_pkg::AEN_BIT]; // RULE2
            autoreset_r    <= reg_wdata[rtcc_pkg::FLAG_BIT]; // RULE3
        end
    end

    // Request bits live one cycle: the transfer completes in that cycle
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            load_req_r <= 1'b0;
            snap_req_r <= 1'b0;
        end else begin
            load_req_r <= wr_tactl && reg_wdata[rtcc_pkg::LOAD_BIT]; // RULE5
            snap_req_r <= wr_tactl && reg_wdata[rtcc_pkg::SNAP_BIT]; // RULE6
        end
    end

    // A match in the clearing cycle still sets the flag
    always_comb begin
        alarm_flag_nxt = alarm_flag_r;
        if (osc_tick) begin
            alarm_flag_nxt = 1'b0; // RULE4
        end
        if (wr_tactl) begin
            alarm_flag_nxt = 1'b0; // RULE2
        end
        if (match) begin
            alarm_flag_nxt = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            alarm_flag_r <= 1'b0;
        end else begin
            alarm_flag_r <= alarm_flag_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Snapshot wins over a software write to a capture byte in the same cycle
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < 4; i++) begin
                capt_r[i] <= rtcc_pkg::BYTE_RST;
            end
        end else if (snap_req_r) begin
            for (int i = 0; i < 4; i++) begin
                capt_r[i] <= count[8*i +: 8]; // RULE6
            end
        end else if (reg_wr && reg_addr <= rtcc_pkg::CAPT3_ADDR) begin
            capt_r[reg_addr[1:0]] <= reg_wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < 4; i++) begin
                alarm_r[i] <= rtcc_pkg::BYTE_RST;
            end
        end else if (reg_wr && reg_addr >= rtcc_pkg::ALARM0_ADDR
                     && reg_addr <= rtcc_pkg::ALARM3_ADDR) begin
            alarm_r[reg_addr[1:0]] <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            gain_r <= rtcc_pkg::OSCCTL_RST[rtcc_pkg::GAIN_BIT];
            mode_r <= rtcc_pkg::OSCCTL_RST[rtcc_pkg::MODE_BIT];
            bias_r <= rtcc_pkg::OSCCTL_RST[rtcc_pkg::BIAS_BIT];
            lfo_r  <= rtcc_pkg::OSCCTL_RST[rtcc_pkg::LFO_BIT];
        end else if (wr_osc) begin
            gain_r <= reg_wdata[rtcc_pkg::GAIN_BIT]; // RULE7
            mode_r <= reg_wdata[rtcc_pkg::MODE_BIT]; // RULE8
            bias_r <= reg_wdata[rtcc_pkg::BIAS_BIT]; // RULE9
            lfo_r  <= reg_wdata[rtcc_pkg::LFO_BIT]; // RULE11
        end
    end

    // Amplitude detector is analog; registered once before software sees it
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            valid_r <= 1'b0;
        end else begin
            valid_r <= amp_ok; // RULE10
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            gain_control_enable  <= 1'b0;
            crystal_mode         <= 1'b0;
            bias_doubling_enable <= 1'b0;
            lfo_enable           <= 1'b0;
            clock_source         <= rtcc_pkg::SRC_SELF;
            alarm_event          <= 1'b0;
        end else begin
            gain_control_enable  <= gain_r; // RULE7
            crystal_mode         <= mode_r && !lfo_r; // RULE8
            bias_doubling_enable <= bias_r; // RULE9
            lfo_enable           <= lfo_r; // RULE11
            if (lfo_r) begin
                clock_source <= rtcc_pkg::SRC_LFO; // RULE11
            end else if (mode_r) begin
                clock_source <= rtcc_pkg::SRC_XTAL; // RULE8
            end else begin
                clock_source <= rtcc_pkg::SRC_SELF;
            end
            alarm_event <= alarm_flag_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        rdata_nxt = 8'h00;
        if (reg_addr <= rtcc_pkg::CAPT3_ADDR) begin
            rdata_nxt = capt_r[reg_addr[1:0]];
        end else if (reg_addr == rtcc_pkg::TACTL_ADDR) begin
            rdata_nxt[rtcc_pkg::TRUN_BIT] = timer_run_r;
            rdata_nxt[rtcc_pkg::AEN_BIT]  = alarm_enable_r;
            rdata_nxt[rtcc_pkg::FLAG_BIT] = alarm_flag_r; // RULE3
            rdata_nxt[rtcc_pkg::LOAD_BIT] = load_req_r; // RULE5
            rdata_nxt[rtcc_pkg::SNAP_BIT] = snap_req_r; // RULE6
        end else if (reg_addr == rtcc_pkg::OSCCTL_ADDR) begin
            rdata_nxt[rtcc_pkg::GAIN_BIT] = gain_r;
            rdata_nxt[rtcc_pkg::MODE_BIT] = mode_r;
            rdata_nxt[rtcc_pkg::BIAS_BIT] = bias_r;
            rdata_nxt[rtcc_pkg::VLD_BIT]  = valid_r; // RULE10
            rdata_nxt[rtcc_pkg::LFO_BIT]  = lfo_r;
            rdata_nxt[2:0]                = 3'h0; // RULE12
        end else if (reg_addr >= rtcc_pkg::ALARM0_ADDR
                     && reg_addr <= rtcc_pkg::ALARM3_ADDR) begin
            rdata_nxt = alarm_r[reg_addr[1:0]];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rdata_nxt;
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule

// >>> verilog/rtcc_pkg.sv
package rtcc_pkg;
    // Indirect register addresses
    localparam logic [3:0] CAPT0_ADDR   = 4'h0;
    localparam logic [3:0] CAPT3_ADDR   = 4'h3;
    localparam logic [3:0] TACTL_ADDR   = 4'h4;
    localparam logic [3:0] OSCCTL_ADDR  = 4'h5;
    localparam logic [3:0] ALARM0_ADDR  = 4'h8;
    localparam logic [3:0] ALARM3_ADDR  = 4'hb;
    // timer_alarm_control fields
    localparam int TRUN_BIT  = 4;
    localparam int AEN_BIT   = 3;
    localparam int FLAG_BIT  = 2;
    localparam int LOAD_BIT  = 1;
    localparam int SNAP_BIT  = 0;
    // oscillator_control fields
    localparam int GAIN_BIT  = 7;
    localparam int MODE_BIT  = 6;
    localparam int BIAS_BIT  = 5;
    localparam int VLD_BIT   = 4;
    localparam int LFO_BIT   = 3;
    localparam logic [7:0] OSCCTL_RST = 8'h00;
    localparam logic [7:0] TACTL_RST  = 8'h00;
    localparam logic [7:0] BYTE_RST   = 8'h00;
    // Clock source encodings
    localparam logic [1:0] SRC_SELF   = 2'h0;
    localparam logic [1:0] SRC_XTAL   = 2'h1;
    localparam logic [1:0] SRC_LFO    = 2'h2;
endpackage

// >>> verilog/rtcc_timer.sv
`timescale 1ns/100ps
module rtcc_timer #(
    parameter int WIDTH = 32
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic             run,
    input  wire logic             tick,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_val,
    output logic      [WIDTH-1:0] count_r
);
    // Load beats counting so a set or auto-reset never loses to a tick
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            count_r <= '0;
        end else if (load) begin
            count_r <= load_val;
        end else if (run && tick) begin // RULE1
            count_r <= count_r + 1'b1;
        end
    end
endmodule

// >>> tb/rtcc_ctrl_properties.sv
`timescale 1ns/100ps
module rtcc_ctrl_props (
    input wire logic       ref_clk,
    input wire logic       rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       osc_tick,
    input wire logic       amp_ok,
    input wire logic       gain_control_enable,
    input wire logic       crystal_mode,
    input wire logic       bias_doubling_enable,
    input wire logic       lfo_enable,
    input wire logic [1:0] clock_source,
    input wire logic       alarm_event
);
    localparam logic [3:0] OA = rtcc_pkg::OSCCTL_ADDR;
    localparam logic [3:0] TA = rtcc_pkg::TACTL_ADDR;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic osc_wr;
    assign osc_wr = reg_wr && reg_addr == OA;
    ////////////////////////////////////////////////////////////////////////////////
    a_osc_low_zero: assert property (
        reg_rd && reg_addr == OA |=> reg_rdata[2:0] == 3'h0) else $error("osc low bits set");
    // Control bit is registered, then copied to the pin: two edges after the write
    a_gain_follows: assert property (
        osc_wr |-> ##2 gain_control_enable == $past(reg_wdata[rtcc_pkg::GAIN_BIT], 2))
        else $error("gain mismatch");
    a_bias_follows: assert property (
        osc_wr |-> ##2 bias_doubling_enable == $past(reg_wdata[rtcc_pkg::BIAS_BIT], 2))
        else $error("bias mismatch");
    a_mode_follows: assert property (
        osc_wr |-> ##2 crystal_mode
        == $past(reg_wdata[rtcc_pkg::MODE_BIT] && !reg_wdata[rtcc_pkg::LFO_BIT], 2))
        else $error("mode mismatch");
    a_lfo_follows: assert property (
        osc_wr |-> ##2 lfo_enable == $past(reg_wdata[rtcc_pkg::LFO_BIT], 2))
        else $error("lfo select mismatch");
    a_source_map: assert property (
        clock_source == (lfo_enable ? rtcc_pkg::SRC_LFO :
        crystal_mode ? rtcc_pkg::SRC_XTAL : rtcc_pkg::SRC_SELF)) else $error("bad source");
    a_valid_reads: assert property (
        reg_rd && reg_addr == OA && amp_ok == $past(amp_ok)
        |=> reg_rdata[4] == $past(amp_ok)) else $error("valid bit mismatch");
    // Flag only rises on an oscillator cycle
    a_alarm_on_tick: assert property (
        $rose(alarm_event) |-> $past(osc_tick)) else $error("alarm off tick");
    a_load_clears: assert property (
        reg_wr && reg_addr == TA && reg_wdata[1] ##1 !reg_wr ##1 reg_rd && reg_addr == TA
        |=> !reg_rdata[1]) else $error("load request stuck");
endmodule

bind rtcc_ctrl rtcc_ctrl_props u_props (
    .ref_clk              (ref_clk),
    .rst_n                (rst_n),
    .reg_addr             (reg_addr),
    .reg_wdata            (reg_wdata),
    .reg_wr               (reg_wr),
    .reg_rd               (reg_rd),
    .reg_rdata            (reg_rdata),
    .osc_tick             (osc_tick),
    .amp_ok               (amp_ok),
    .gain_control_enable  (gain_control_enable),
    .crystal_mode         (crystal_mode),
    .bias_doubling_enable (bias_doubling_enable),
    .lfo_enable           (lfo_enable),
    .clock_source         (clock_source),
    .alarm_event          (alarm_event)
);

// >>> tb/test_rtc_control_and_osc_config.sv
`timescale 1ns/100ps
module test_rtc_control_and_osc_config;
    localparam logic [3:0] OA = rtcc_pkg::OSCCTL_ADDR;
    localparam logic [3:0] TA = rtcc_pkg::TACTL_ADDR;
    localparam logic [7:0] OW [3] = '{8'hff, 8'h40, 8'ha0};
    localparam logic [7:0] OR [3] = '{8'he8, 8'h40, 8'ha0};
    localparam logic [1:0] OS [3] = '{rtcc_pkg::SRC_LFO, rtcc_pkg::SRC_XTAL, rtcc_pkg::SRC_SELF};
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        osc_tick = 1'b0;
    logic        amp_ok = 1'b0;
    logic [7:0]  reg_rdata;
    logic        gce, cm, bde, lfo, alarm_event;
    logic [1:0]  src;
    logic [31:0] w;
    int          fail_count = 0;
    int          comparisons = 0;

    rtcc_ctrl DUT (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .osc_tick(osc_tick), .amp_ok(amp_ok), .gain_control_enable(gce), .crystal_mode(cm),
        .bias_doubling_enable(bde), .lfo_enable(lfo), .clock_source(src),
        .alarm_event(alarm_event));

    initial forever #4 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////////////////////
    task check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge ref_clk) reg_wr <= 1'b0;
    endtask
    // Data stands one cycle only, so sample just after its edge
    task rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge ref_clk) {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge ref_clk) reg_rd <= 1'b0;
        #1 check(reg_rdata, e);
    endtask
    task tick();
        @(posedge ref_clk) osc_tick <= 1'b1;
        @(posedge ref_clk) osc_tick <= 1'b0;
    endtask
    task wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge ref_clk);
        fail_count++;
        wrap_up();
    end
    initial begin
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(TA, rtcc_pkg::TACTL_RST);
        rd(OA, rtcc_pkg::OSCCTL_RST);
        rd(4'h6, 8'h00);
        for (int i = 0; i < 3; i++) begin
            wr(OA, OW[i]);
            rd(OA, OR[i]);
            check({6'h0, src}, {6'h0, OS[i]});
            check({7'h0, cm}, {7'h0, OW[i][6] & ~OW[i][3]});
            check({6'h0, gce, bde}, {6'h0, OW[i][7], OW[i][5]});
            check({7'h0, lfo}, {7'h0, OW[i][3]});
        end
        @(posedge ref_clk) amp_ok <= 1'b1;
        rd(OA, 8'hb0);
        for (int i = 0; i < 4; i++) wr(4'(i), 8'(16 * (i + 1)));
        wr(TA, 8'h02);
        rd(TA, 8'h00);
        wr(TA, 8'h10);
        repeat (5) tick();
        wr(TA, 8'h00);
        repeat (3) tick();
        wr(TA, 8'h01);
        rd(TA, 8'h00);
        w = 32'h40302015;
        for (int i = 0; i < 4; i++) rd(4'(i), w[8*i +: 8]);
        w = 32'h40302017;
        for (int i = 0; i < 4; i++) wr(4'(8 + i), w[8*i +: 8]);
        wr(TA, 8'h1c);
        repeat (3) tick();
        #1 check({7'h0, alarm_event}, 8'h01);
        rd(TA, 8'h1c);
        tick();
        #1 check({7'h0, alarm_event}, 8'h00);
        wr(TA, 8'h19);
        rd(4'h0, 8'h01);
        // Raise the flag again, then clear it by a write with no tick between
        w = 32'h00000001;
        for (int i = 0; i < 4; i++) wr(4'(8 + i), w[8*i +: 8]);
        tick();
        #1 check({7'h0, alarm_event}, 8'h01);
        wr(TA, 8'h18);
        rd(TA, 8'h18);
        check({7'h0, alarm_event}, 8'h00);
        wrap_up();
    end
endmodule
